// ### src/pli_defs.svh
// offsets, fields, reset values and timing figures of the led indicator block
// assumes a 250 MHz system clock; included by the package, the stretcher and the controller
`ifndef PLI_DEFS_SVH
`define PLI_DEFS_SVH
`define PLI_ADDR_W          12
`define PLI_CTRL_OFF        12'h000
`define PLI_STATUS_OFF      12'h004
`define PLI_CTRL_RESET      16'h3422
`define PLI_FIRST_HI        11
`define PLI_FIRST_LO        8
`define PLI_SECOND_HI       7
`define PLI_SECOND_LO       4
`define PLI_SEL_HI          3
`define PLI_SEL_LO          2
`define PLI_STRETCH_BIT     1
`define PLI_CODE_TX         4'h1
`define PLI_CODE_RX         4'h2
`define PLI_CODE_COL        4'h3
`define PLI_CODE_LINK       4'h4
`define PLI_CODE_DUPLEX     4'h5
`define PLI_CODE_TXRX       4'h7
`define PLI_CODE_ON         4'h8
`define PLI_CODE_OFF        4'h9
`define PLI_CODE_FAST       4'hA
`define PLI_CODE_SLOW       4'hB
`define PLI_CODE_LINK_RX    4'hC
`define PLI_CODE_LINK_TXRX  4'hD
`define PLI_CODE_DUP_COL    4'hE
`define PLI_SEL_NORMAL      2'h0
`define PLI_SEL_MEDIUM      2'h1
`define PLI_SEL_LONG        2'h2
`define PLI_CLK_KHZ         250000
`define PLI_NORMAL_MS       40
`define PLI_MEDIUM_MS       70
`define PLI_LONG_MS         140
`define PLI_SLOW_HALF_MS    500
`define PLI_FAST_HALF_MS    125
`define PLI_SETTLE_CYCLES   5'h10
`define PLI_CNT_W           27
`define PLI_RESP_OKAY       2'h0
`define PLI_RESP_SLVERR     2'h2
`endif

// ### src/pli_pkg.sv
// types shared by the led indicator modules
// assumes nothing beyond the defines header
`include "pli_defs.svh"
package pli_pkg;
    typedef enum logic {PLI_DETECT, PLI_RUN} pli_state_t;
    typedef logic [`PLI_CNT_W-1:0] pli_count_t;
endpackage

// ### src/pli_stretch_if.sv
// link between an indicator and its activity stretcher
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface pli_stretch_if;
    logic       evt;
    logic       stretchOn;
    logic [1:0] timeSel;
    logic       active;
    modport drv (output evt, output stretchOn, output timeSel, input active);
    modport str (input evt, input stretchOn, input timeSel, output active);
endinterface

// ### src/pli_stretch.sv
// activity pulse stretcher for one indicator
// assumes events are synchronous to sys_clk; counts come from the top
`timescale 1ns/1ps
`include "pli_defs.svh"
module pli_stretch
    import pli_pkg::*;
#(
    parameter pli_count_t NORMAL_CYCLES = pli_count_t'(10000000),
    parameter pli_count_t MEDIUM_CYCLES = pli_count_t'(17500000),
    parameter pli_count_t LONG_CYCLES   = pli_count_t'(35000000)
) (
    // clock and reset
    input wire logic   sys_clk,
    input wire logic   rst_n,
    // indicator side
    pli_stretch_if.str port
);
    pli_count_t remain;
    pli_count_t dur;
    pli_count_t next_remain;

    // reserved select falls back to the normal length
    always_comb begin
        dur = NORMAL_CYCLES;
        if (port.timeSel == `PLI_SEL_MEDIUM) begin
            dur = MEDIUM_CYCLES;
        end else if (port.timeSel == `PLI_SEL_LONG) begin
            dur = LONG_CYCLES;
        end
        next_remain = '0;
        if (port.evt && port.stretchOn) begin
            next_remain = dur; // RQ1
        end else if (port.stretchOn && remain != '0) begin
            next_remain = remain - pli_count_t'(1);
        end
    end

    // a new event restarts the window rather than adding to it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            remain      <= '0;
            port.active <= 1'b0;
        end else begin
            remain      <= next_remain;
            port.active <= port.evt | (next_remain != '0); // RQ1
        end
    end

    a_stretch_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
        (port.evt && port.stretchOn && NORMAL_CYCLES >= pli_count_t'(8))
        ##1 (port.stretchOn && port.timeSel == `PLI_SEL_NORMAL)[*8]
        |-> $past(port.active, 1) && $past(port.active, 7))
        else $error("stretched pulse ended early");
    a_plain_follow: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6
        !port.stretchOn |=> port.active == $past(port.evt))
        else $error("unstretched pulse does not follow event");
endmodule

// ### src/pli_led_ctrl.sv
// led indicator controller with axi4-lite register access
// assumes activity inputs come from logic on sys_clk; led pins are external
//
// Functional notes
// (RQ1) three stretch lengths, normal medium long, lengthen stretchable events
// (RQ2) code 1110 shows duplex overlaid by always-stretched collision activity
// (RQ3) code 1101 shows link with tx and rx activity, always stretched
// (RQ4) code 1100 shows link with rx activity, always stretched
// (RQ5) 1011 slow blink, 1010 fast blink, 1001 off, 1000 on
// (RQ6) code 0111 shows tx or rx activity, stretched only when enabled
// (RQ7) code 0101 shows duplex status; 0110 is reserved
// (RQ8) code 0100 lights the indicator while the link is up
// (RQ9) code 0011 shows collision activity, stretched only when enabled
// (RQ10) code 0010 shows rx activity, stretched only when enabled
// (RQ11) code 0001 shows tx activity, stretched only when enabled
// (RQ12) software never programs code 1111 into either field
// (RQ13) second indicator field in bits 7..4 uses the same codes
// (RQ14) after reset each pin's led wiring is sensed and drive matches it
// (RQ15) wiring sensed once per reset; later changes are ignored
// (RQ16) sinking led on second pin sets full duplex bit, sourcing clears
// (RQ17) reset: first code link, second rx, stretch time 00, stretch on
// (RQ18) reserved bits writable; blink rates from fixed clock dividers
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "pli_defs.svh"
module pli_led_ctrl
    import pli_pkg::*;
#(
    parameter pli_count_t NORMAL_CYCLES = pli_count_t'(`PLI_NORMAL_MS * `PLI_CLK_KHZ),
    parameter pli_count_t MEDIUM_CYCLES = pli_count_t'(`PLI_MEDIUM_MS * `PLI_CLK_KHZ),
    parameter pli_count_t LONG_CYCLES   = pli_count_t'(`PLI_LONG_MS * `PLI_CLK_KHZ),
    parameter pli_count_t SLOW_CYCLES   = pli_count_t'(`PLI_SLOW_HALF_MS * `PLI_CLK_KHZ),
    parameter pli_count_t FAST_CYCLES   = pli_count_t'(`PLI_FAST_HALF_MS * `PLI_CLK_KHZ)
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // axi4-lite write
    input  wire logic [`PLI_ADDR_W-1:0] awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    // axi4-lite read
    input  wire logic [`PLI_ADDR_W-1:0] araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    // phy status and activity
    input  wire logic                   linkUp,
    input  wire logic                   duplexFull,
    input  wire logic                   txActivity,
    input  wire logic                   rxActivity,
    input  wire logic                   collision,
    // led pins
    input  wire logic [1:0]             ledIn,
    output logic [1:0]                  ledOut,
    output logic [1:0]                  ledOe,
    // duplex default for the phy
    output logic                        phyFullDuplexBit
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic regHit(input logic [`PLI_ADDR_W-1:0] a,
                                    input logic [`PLI_ADDR_W-1:0] off);
        regHit = (a[`PLI_ADDR_W-1:2] == off[`PLI_ADDR_W-1:2]);
    endfunction

    // both fields share one decoder
    function automatic logic [3:0] codeOf(input logic [15:0] c, input int idx);
        codeOf = (idx == 0) ? c[`PLI_FIRST_HI:`PLI_FIRST_LO]
                            : c[`PLI_SECOND_HI:`PLI_SECOND_LO]; // RQ13
    endfunction

    function automatic logic pickEvent(input logic [3:0] code,
                                       input logic tx, input logic rx,
                                       input logic col);
        case (code)
            `PLI_CODE_TX:        pickEvent = tx;      // RQ11
            `PLI_CODE_RX:        pickEvent = rx;      // RQ10
            `PLI_CODE_COL:       pickEvent = col;     // RQ9
            `PLI_CODE_TXRX:      pickEvent = tx | rx; // RQ6
            `PLI_CODE_LINK_RX:   pickEvent = rx;      // RQ4
            `PLI_CODE_LINK_TXRX: pickEvent = tx | rx; // RQ3
            `PLI_CODE_DUP_COL:   pickEvent = col;     // RQ2
            default:             pickEvent = 1'b0;
        endcase
    endfunction

    function automatic logic alwaysStretch(input logic [3:0] code);
        alwaysStretch = (code == `PLI_CODE_LINK_RX) || (code == `PLI_CODE_LINK_TXRX)
                     || (code == `PLI_CODE_DUP_COL); // RQ2 RQ3 RQ4
    endfunction

    // activity inverts the steady level, so a lit led blinks dark and a dark one blinks lit
    function automatic logic litOf(input logic [3:0] code, input logic act,
                                   input logic link, input logic dup,
                                   input logic slow, input logic fast);
        case (code)
            `PLI_CODE_TX, `PLI_CODE_RX, `PLI_CODE_COL,
            `PLI_CODE_TXRX:      litOf = act;
            `PLI_CODE_LINK:      litOf = link;       // RQ8
            `PLI_CODE_DUPLEX:    litOf = dup;        // RQ7
            `PLI_CODE_ON:        litOf = 1'b1;       // RQ5
            `PLI_CODE_OFF:       litOf = 1'b0;       // RQ5
            `PLI_CODE_FAST:      litOf = fast;       // RQ5
            `PLI_CODE_SLOW:      litOf = slow;       // RQ5
            `PLI_CODE_LINK_RX,
            `PLI_CODE_LINK_TXRX: litOf = link ^ act; // RQ3 RQ4
            `PLI_CODE_DUP_COL:   litOf = dup ^ act;  // RQ2
            default:             litOf = 1'b0;       // reserved codes stay dark
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register bus slave

    logic [15:0]            ctrl;
    logic                   awHeld;
    logic                   wHeld;
    logic [`PLI_ADDR_W-1:0] awAddrReg;
    logic [15:0]            wDataReg;
    logic [1:0]             wStrbReg;
    logic                   doWrite;
    logic                   next_awHeld;
    logic                   next_wHeld;
    logic                   next_bvalid;
    pli_state_t             state;
    logic [1:0]             polSink;
    logic [31:0]            statusWord;

    // address and data may come in either order
    always_comb begin
        doWrite     = awHeld & wHeld & ~bvalid;
        next_awHeld = ~doWrite & (awHeld | (awvalid & awready));
        next_wHeld  = ~doWrite & (wHeld | (wvalid & wready));
        next_bvalid = doWrite | (bvalid & ~bready);
    end

    // write side: one transaction in flight
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld    <= 1'b0;
            wHeld     <= 1'b0;
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= `PLI_RESP_OKAY;
            awAddrReg <= '0;
            wDataReg  <= 16'h0000;
            wStrbReg  <= 2'h0;
        end else begin
            awHeld  <= next_awHeld;
            wHeld   <= next_wHeld;
            awready <= ~next_awHeld & ~next_bvalid;
            wready  <= ~next_wHeld & ~next_bvalid;
            bvalid  <= next_bvalid;
            if (awvalid && awready) begin
                awAddrReg <= awaddr;
            end
            if (wvalid && wready) begin
                wDataReg <= wdata[15:0];
                wStrbReg <= wstrb[1:0];
            end
            if (doWrite) begin
                bresp <= (regHit(awAddrReg, `PLI_CTRL_OFF) ||
                          regHit(awAddrReg, `PLI_STATUS_OFF)) ? `PLI_RESP_OKAY
                                                              : `PLI_RESP_SLVERR;
            end
        end
    end

    // control word; all sixteen bits are writable, reserved ones included
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `PLI_CTRL_RESET; // RQ17
        end else if (doWrite && regHit(awAddrReg, `PLI_CTRL_OFF)) begin
            if (wStrbReg[0]) begin
                ctrl[7:0] <= wDataReg[7:0]; // RQ18
            end
            if (wStrbReg[1]) begin
                ctrl[15:8] <= wDataReg[15:8]; // RQ18
            end
        end
    end

    // status shows live inputs, sensed wiring and what each led shows
    assign statusWord = {24'h000000, phyFullDuplexBit, state == PLI_RUN, polSink,
                         ledOut ^ polSink, duplexFull, linkUp};

    // read side answers one cycle after the address is taken
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `PLI_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `PLI_RESP_OKAY;
            rdata   <= 32'h00000000;
            if (regHit(araddr, `PLI_CTRL_OFF)) begin
                rdata <= {16'h0000, ctrl};
            end else if (regHit(araddr, `PLI_STATUS_OFF)) begin
                rdata <= statusWord;
            end else begin
                rresp <= `PLI_RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // led wiring detection

    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    logic [4:0] settleCnt;

    // pins are undriven during detection, so they float to the led's rail
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= 2'h0;
            pinSync <= 2'h0;
        end else begin
            pinMeta <= ledIn;
            pinSync <= pinMeta;
        end
    end

    // sensed once per reset; a rewired led is only seen after the next one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state            <= PLI_DETECT;
            settleCnt        <= 5'h00;
            polSink          <= 2'h0;
            phyFullDuplexBit <= 1'b0;
        end else begin
            case (state)
                PLI_DETECT: begin
                    settleCnt <= settleCnt + 5'h01;
                    if (settleCnt == `PLI_SETTLE_CYCLES - 5'h01) begin
                        polSink          <= pinSync;    // RQ14
                        phyFullDuplexBit <= pinSync[1]; // RQ16
                        state            <= PLI_RUN;
                    end
                end
                PLI_RUN: begin
                    state <= PLI_RUN; // RQ15
                end
                default: begin
                    state <= PLI_DETECT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // blink dividers

    logic [1:0] blinkPhase;

    generate
        for (genvar b = 0; b < 2; b++) begin : g_blink
            localparam pli_count_t HALF = (b == 0) ? SLOW_CYCLES : FAST_CYCLES;
            pli_count_t cnt;
            logic       phase;
            // free running so both indicators blink in step
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt   <= '0;
                    phase <= 1'b0;
                end else if (cnt == HALF - pli_count_t'(1)) begin
                    cnt   <= '0;
                    phase <= ~phase; // RQ18
                end else begin
                    cnt <= cnt + pli_count_t'(1);
                end
            end
            assign blinkPhase[b] = phase;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // indicators

    pli_stretch_if sif [2] ();
    logic [1:0]    litNow;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_ind
            assign sif[i].evt       = pickEvent(codeOf(ctrl, i), txActivity,
                                                rxActivity, collision);
            assign sif[i].stretchOn = alwaysStretch(codeOf(ctrl, i))
                                    | ctrl[`PLI_STRETCH_BIT]; // RQ6 RQ9
            assign sif[i].timeSel   = ctrl[`PLI_SEL_HI:`PLI_SEL_LO];
            assign litNow[i]        = litOf(codeOf(ctrl, i), sif[i].active, linkUp,
                                            duplexFull, blinkPhase[0], blinkPhase[1]);
            pli_stretch #(
                .NORMAL_CYCLES (NORMAL_CYCLES),
                .MEDIUM_CYCLES (MEDIUM_CYCLES),
                .LONG_CYCLES   (LONG_CYCLES)
            ) u_stretch (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .port    (sif[i])
            );
        end
    endgenerate

    // a sinking led lights on a low drive; pins stay released until sensed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ledOut <= 2'h0;
            ledOe  <= 2'h0;
        end else if (state == PLI_RUN) begin
            ledOut <= litNow ^ polSink; // RQ14
            ledOe  <= 2'h3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_detect_latch: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ14
        $rose(state == PLI_RUN) |-> polSink == $past(pinSync) && ledOe == 2'h0)
        else $error("wiring not taken from the pins");
    a_polarity_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ15
        state == PLI_RUN && $past(state == PLI_RUN) |-> $stable(polSink))
        else $error("polarity changed while running");
    a_duplex_strap: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ16
        state == PLI_RUN |-> phyFullDuplexBit == polSink[1])
        else $error("duplex bit disagrees with second pin wiring");
    a_link_show: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ8
        $past(state == PLI_RUN) && $past(codeOf(ctrl, 0)) == `PLI_CODE_LINK
        |-> ledOut[0] == ($past(linkUp) ^ polSink[0]))
        else $error("link code does not follow link");
    a_off_code: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ5
        $past(state == PLI_RUN) && $past(codeOf(ctrl, 0)) == `PLI_CODE_OFF
        |-> ledOut[0] == polSink[0])
        else $error("off code lit the led");
    a_on_code: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ13
        $past(state == PLI_RUN) && $past(codeOf(ctrl, 1)) == `PLI_CODE_ON
        |-> ledOut[1] == ~polSink[1])
        else $error("on code left second led dark");
    a_tx_plain: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ11
        $past(state == PLI_RUN, 2) && $past(codeOf(ctrl, 0), 2) == `PLI_CODE_TX
        && $past(codeOf(ctrl, 0)) == `PLI_CODE_TX && !$past(ctrl[`PLI_STRETCH_BIT], 2)
        |-> ledOut[0] == ($past(txActivity, 2) ^ polSink[0]))
        else $error("tx activity not shown two cycles later");
    a_forced_stretch: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
        (rxActivity && codeOf(ctrl, 1) == `PLI_CODE_LINK_TXRX && !ctrl[`PLI_STRETCH_BIT])
        ##1 (!rxActivity && !txActivity && codeOf(ctrl, 1) == `PLI_CODE_LINK_TXRX)
        |=> sif[1].active)
        else $error("link activity not stretched");
    a_dup_col: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ2
        (collision && codeOf(ctrl, 0) == `PLI_CODE_DUP_COL && !ctrl[`PLI_STRETCH_BIT])
        ##1 (!collision && codeOf(ctrl, 0) == `PLI_CODE_DUP_COL)
        |=> sif[0].active)
        else $error("collision overlay not stretched");
    a_write_ctrl: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ18
        doWrite && regHit(awAddrReg, `PLI_CTRL_OFF) && wStrbReg == 2'h3
        |=> ctrl == $past(wDataReg) && bvalid)
        else $error("control write lost");
endmodule

// ### test/pli_led_model.sv
// partner model: two leds hanging on the indicator pins
// assumes a released pin rests at the rail the led is tied to
`timescale 1ns/1ps
module pli_led_model (
    // pin side
    input  wire logic [1:0] ledOut,
    input  wire logic [1:0] ledOe,
    // wiring, 1 = led to supply, lit by sinking
    input  wire logic [1:0] sink,
    output logic      [1:0] ledIn,
    output logic      [1:0] lit
);
    // an undriven pin is pulled through the led to its rail
    assign ledIn = (ledOe & ledOut) | (~ledOe & sink);
    // current flows only while the drive opposes the rail
    assign lit = ledOe & (ledOut ^ sink);
endmodule

// ### test/pli_led_ctrl_bench.sv
// self-checking bench for the led indicator controller
// assumes short stretch and blink counts set at the instance
`timescale 1ns/1ps
`include "pli_defs.svh"
module pli_led_ctrl_bench;
    logic        sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, phyFullDuplexBit;
    logic        linkUp, duplexFull;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, ledOut, ledOe, ledIn, lit, sink, rs;
    logic [2:0]  act;
    logic [3:0]  wstrb;
    int          num_errors, samples_checked, cyc;

    ////////////////////////////////////////////////////////////
    // small counts keep each stretch and blink short
    pli_led_ctrl #(.NORMAL_CYCLES(20), .MEDIUM_CYCLES(30), .LONG_CYCLES(40),
                   .SLOW_CYCLES(64), .FAST_CYCLES(16)) dut (
        .sys_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .linkUp, .duplexFull,
        .txActivity(act[0]), .rxActivity(act[1]), .collision(act[2]),
        .ledIn, .ledOut, .ledOe, .phyFullDuplexBit);
    pli_led_model leds (.ledOut, .ledOe, .sink, .ledIn, .lit);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // cut a hang short; the whole run needs under 2000 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // control word; codes stay clear of 1111
    function automatic logic [31:0] cv(logic [3:0] a, logic [3:0] b, logic [1:0] s,
                                       logic e);
        return {20'h0, a, b, s, e, 1'b0};
    endfunction

    // same code on both indicators so the second one is exercised too
    function automatic logic [31:0] cv2(logic [3:0] c, logic [1:0] s, logic e);
        return cv(c, c, s, e);
    endfunction

    // aw and w offered together, each dropped once taken
    task automatic wr(logic [11:0] a, logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
    endtask

    task automatic rdr(logic [11:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
    endtask

    task automatic cnt(int i, int n, int e);
        int c = 0;
        repeat (n) @(posedge sys_clk) if (lit[i] === 1'b1) c++;
        chk("lit cycles", e, c);
    endtask

    task automatic see(logic [1:0] e);
        repeat (3) @(posedge sys_clk);
        chk("lit", e, lit);
    endtask

    // one-cycle event with the same code on both indicators, then count lit cycles of the first
    task automatic pulse(logic [3:0] c, logic en, logic [2:0] ev, logic [1:0] s, int e);
        wr(`PLI_CTRL_OFF, cv2(c, s, en));
        act <= ev;
        @(posedge sys_clk);
        act <= 3'h0;
        cnt(0, 60, e);
    endtask

    // led rails must be steady before release, as detection reads them
    task automatic restart();
        rst_n <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (25) @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        {awvalid, wvalid, arvalid, act} <= '0;
        // answers are always taken at once, so bready and rready stay high
        {bready, rready, wstrb} <= 6'h3F;
        {awaddr, araddr, wdata} <= '0;
        {linkUp, duplexFull} <= 2'b10;
        sink <= 2'b10;
        restart();
        chk("duplex bit", 1, phyFullDuplexBit);
        chk("pin enables", 3, ledOe);
        rdr(`PLI_CTRL_OFF);
        chk("control reset", 32'h0000_3422, rd);
        rdr(`PLI_STATUS_OFF);
        chk("wiring", 2'b10, rd[5:4]);
        wr(`PLI_CTRL_OFF, 32'h0000_A894);
        rdr(`PLI_CTRL_OFF);
        chk("control", 32'h0000_A894, rd);
        wstrb <= 4'h1;
        wr(`PLI_CTRL_OFF, 32'h0000_0054);
        wstrb <= 4'hF;
        rdr(`PLI_CTRL_OFF);
        chk("byte write", 32'h0000_A854, rd);
        rdr(12'h100);
        chk("unmapped read", 2'h2, rs);
        wr(12'h100, 32'h0);
        chk("unmapped write", 2'h2, rs);
        wr(`PLI_CTRL_OFF, cv(4'h8, 4'h9, 2'h0, 1'b0));
        see(2'b01);
        wr(`PLI_CTRL_OFF, cv(4'h9, 4'h8, 2'h0, 1'b0));
        see(2'b10);
        wr(`PLI_CTRL_OFF, cv(4'h4, 4'h5, 2'h0, 1'b0));
        see(2'b01);
        {linkUp, duplexFull} <= 2'b01;
        see(2'b10);
        {linkUp, duplexFull} <= 2'b00;
        wr(`PLI_CTRL_OFF, cv(4'hA, 4'h9, 2'h0, 1'b0));
        cnt(0, 64, 32);
        wr(`PLI_CTRL_OFF, cv(4'hB, 4'h9, 2'h0, 1'b0));
        cnt(0, 128, 64);
        pulse(4'h1, 1'b0, 3'h1, 2'h0, 1);
        pulse(4'h2, 1'b1, 3'h2, 2'h0, 20);
        pulse(4'h3, 1'b0, 3'h4, 2'h0, 1);
        pulse(4'h7, 1'b1, 3'h1, 2'h0, 20);
        pulse(4'hC, 1'b0, 3'h2, 2'h0, 20);
        pulse(4'hC, 1'b0, 3'h1, 2'h0, 0);
        pulse(4'hD, 1'b0, 3'h1, 2'h0, 20);
        pulse(4'hD, 1'b0, 3'h2, 2'h0, 20);
        pulse(4'hE, 1'b0, 3'h4, 2'h0, 20);
        pulse(4'h1, 1'b1, 3'h1, 2'h1, 30);
        pulse(4'h1, 1'b1, 3'h1, 2'h2, 40);
        pulse(4'h1, 1'b1, 3'h1, 2'h3, 20);
        sink <= 2'b01;
        rdr(`PLI_STATUS_OFF);
        chk("wiring held", 2'b10, rd[5:4]);
        restart();
        chk("duplex bit", 0, phyFullDuplexBit);
        rdr(`PLI_STATUS_OFF);
        chk("wiring", 2'b01, rd[5:4]);
        give_verdict();
    end
endmodule
